// File: core/fdd_consts.svh
// Constants of the fault detect and dispatch block: offsets, codes and record layout.
// Assumes byte addressing on both the APB slave and the memory master port.
`ifndef FDD_CONSTS_SVH
`define FDD_CONSTS_SVH

`define FDD_REG_TBASE    8'h00
`define FDD_REG_SBASE    8'h04
`define FDD_REG_STAT     8'h08
`define FDD_REG_FWORD    8'h0C
`define FDD_REG_IRQ_STAT 8'h10
`define FDD_REG_IRQ_EN   8'h14
`define FDD_REG_IRQ_CLR  8'h18
`define FDD_REG_COUNT    8'h1C
`define FDD_REG_WIN      8'h40
`define FDD_TBASE_RST    32'h00000000
`define FDD_SBASE_RST    32'h00000000

`define FDD_IRQ_DISPATCH 0
`define FDD_IRQ_DROPPED  1
`define FDD_IRQ_NESTED   2
`define FDD_IRQ_BADENT   3

`define FDD_RES_OFS0     8'h00
`define FDD_RES_OFS1     8'h04
`define FDD_REC_PC_OFS   8'h20
`define FDD_REC_AC_OFS   8'h24
`define FDD_REC_FW_OFS   8'h28
`define FDD_REC_IP_OFS   8'h2C
`define FDD_ENT_WORD2    32'h00000004

`define FDD_TYPE_TRACE   8'h01
`define FDD_TYPE_OPER    8'h02
`define FDD_TYPE_ARITH   8'h03
`define FDD_TYPE_FP      8'h04
`define FDD_TYPE_CONSTR  8'h05
`define FDD_TYPE_PROT    8'h07
`define FDD_TYPE_MACH    8'h08
`define FDD_TYPE_STRUCT  8'h09
`define FDD_TYPE_TYPE    8'h0A

`define FDD_SUB_INV_OPC  16'h0001
`define FDD_SUB_UNIMPL   16'h0002
`define FDD_SUB_INV_OPND 16'h0004
`define FDD_SUB_INT_OVF  16'h0001
`define FDD_SUB_ZDIV     16'h0002
`define FDD_SUB_RANGE    16'h0001
`define FDD_SUB_PRIV     16'h0002
`define FDD_SUB_LENGTH   16'h0001
`define FDD_SUB_BAD_ACC  16'h0001
`define FDD_SUB_IAGENT   16'h0003
`define FDD_SUB_MISMATCH 16'h0001

`define FDD_ENT_LOCAL    2'b00
`define FDD_ENT_SYSTEM   2'b10
`define FDD_SYS_SUPER    2'b10

`endif

// File: core/fdd_pkg.sv
// Types shared by the fault detect and dispatch block.
// Assumes fdd_consts.svh for all numeric values.
package fdd_pkg;

	typedef struct packed {
		logic [7:1] trace;
		logic [2:0] oper;
		logic [1:0] arith;
		logic [5:0] fp;
		logic [1:0] constr;
		logic       prot;
		logic       mach;
		logic       interagent_message;
		logic       type_mm;
	} fdd_fault_t;

	typedef struct packed {
		logic [31:0] proc_ctrl;
		logic [31:0] arith_ctrl;
		logic [31:0] ip;
		logic [31:0] sp;
		logic [31:0] resume0;
		logic [31:0] resume1;
		logic        incomplete;
	} fdd_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} fdd_apb_req_t;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} fdd_mreq_t;

	typedef enum logic [1:0] {
		FDD_CALL_LOCAL,
		FDD_CALL_SYS_LOCAL,
		FDD_CALL_SUPER
	} fdd_call_t;

	typedef struct packed {
		fdd_call_t   kind;
		logic [31:0] target;
		logic [31:0] fault_word;
	} fdd_call_info_t;

endpackage

// File: core/fdd_rec_mem.sv
// Sixteen-word mirror of the last fault record, read back by software.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/10ps
module fdd_rec_mem (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Write port
	input  wire logic        we_i,
	input  wire logic [3:0]  waddr_i,
	input  wire logic [31:0] wdata_i,
	// Read port
	input  wire logic [3:0]  raddr_i,
	output logic      [31:0] rdata_o
);
	logic [31:0] mem_ff [16];
	logic [31:0] rdata_ff;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_ff[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h00000000;
		end else begin
			rdata_ff <= mem_ff[raddr_i];
		end
	end

	assign rdata_o = rdata_ff;
endmodule

// File: core/fdd_core.sv
// Fault detect and dispatch: encodes faults, writes records, fetches the handler.
// Assumes a word memory port with a held request and one-cycle ack, and an APB master.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "fdd_consts.svh"

// Behaviour
// - Take every fault at once, independent of software; the core stalls a fault while a record is built or the handler fetched.
// - Save program, instruction and fault state first.
// - Fault record goes on the current stack.
// - Incomplete instruction pushes a resumption record.
// - Handler chosen by type number only.
// - Table fetched only after records are written.
// - Call is local, system local or supervisor.
// - Interrupt-time faults use the same call path.
// - Fault word at offset 40: type, subtype.
// - Trace type 1, one bit per cause.
// - Flag types merge simultaneous subtype bits.
// - Operation type 2: subtypes 1, 2, 4.
// - Arithmetic type 3: overflow 1, zero-divide 2.
// - Floating type 4: flag bits 0 to 5.
// - Codes for types 5, 7, 8, 9, A.
// - Other simultaneous faults: record one, hide rest.
// - Fault inside a handler has no defined outcome.
// - Table entry read as two words by type.
// - Entry type 00 local, 10 system call.
module fdd_core
	import fdd_pkg::*;
(
	// Clock and reset
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	// Fault conditions and program state from the core
	input  wire fdd_fault_t     fault_i,
	input  wire fdd_state_t     state_i,
	input  wire logic           in_intr_i,
	output logic                fault_ready_o,
	// Handler call towards the core
	output logic                call_o,
	output fdd_call_info_t      call_info_o,
	input  wire logic           hdone_i,
	// Memory master
	output fdd_mreq_t           mreq_o,
	input  wire logic           mack_i,
	input  wire logic [31:0]    mrdata_i,
	// APB slave
	input  wire fdd_apb_req_t   apb_i,
	output logic                pready_o,
	output logic                pslverr_o,
	output logic [31:0]         prdata_o,
	// Interrupt
	output logic                irq_o
);
	typedef enum logic [2:0] {
		S_IDLE, S_WR_RES, S_WR_REC, S_RD_ENT0, S_RD_ENT1, S_RD_SYS, S_CALL, S_HANDLER
	} fdd_state_e_t;

	fdd_state_e_t   state_ff;
	fdd_state_e_t   nxt_state;
	fdd_state_t     snap_ff;
	logic [31:0]    fword_ff;
	logic [31:0]    ent0_ff;
	logic [7:0]     ofs_ff;
	logic [31:0]    tbase_ff;
	logic [31:0]    sbase_ff;
	logic [3:0]     irq_stat_ff;
	logic [3:0]     irq_en_ff;
	logic [31:0]    count_ff;
	logic [31:0]    prdata_ff;
	logic           win_ff;
	logic           rec_done_ff;
	logic           call_ff;
	fdd_call_info_t call_info_ff;
	logic [24:0]    enc;
	logic           take;
	logic           step;
	logic [3:0]     ev;
	logic [31:0]    mem_rdata;

	// Only one fault may be in flight, so the core stalls its next fault while a
	// record is being built. Handler code runs in S_HANDLER and may fault again.
	function automatic logic [24:0] fdd_encode(input fdd_fault_t f);
		logic [8:0]  tp;
		logic [7:0]  t;
		logic [15:0] s;
		logic        multi;
		tp = {f.type_mm, f.interagent_message, f.mach, f.prot, |f.constr, |f.fp,
			|f.arith, |f.oper, |f.trace};
		t = 8'h00;
		s = 16'h0000;
		multi = ($countones(tp) > 1) || ($countones(f.oper) > 1) || (&f.arith)
			|| (&f.constr);
		if (f.mach) begin
			t = `FDD_TYPE_MACH;
			s = `FDD_SUB_BAD_ACC;
		end else if (f.interagent_message) begin
			t = `FDD_TYPE_STRUCT;
			s = `FDD_SUB_IAGENT;
		end else if (f.type_mm) begin
			t = `FDD_TYPE_TYPE;
			s = `FDD_SUB_MISMATCH;
		end else if (f.prot) begin
			t = `FDD_TYPE_PROT;
			s = `FDD_SUB_LENGTH;
		end else if (|f.constr) begin
			t = `FDD_TYPE_CONSTR;
			s = f.constr[0] ? `FDD_SUB_RANGE : `FDD_SUB_PRIV;
		end else if (|f.oper) begin
			t = `FDD_TYPE_OPER;
			s = f.oper[0] ? `FDD_SUB_INV_OPC : (f.oper[1] ? `FDD_SUB_UNIMPL : `FDD_SUB_INV_OPND);
		end else if (|f.arith) begin
			t = `FDD_TYPE_ARITH;
			s = f.arith[0] ? `FDD_SUB_INT_OVF : `FDD_SUB_ZDIV;
		end else if (|f.fp) begin
			t = `FDD_TYPE_FP;
			s = {10'h000, f.fp};
		end else if (|f.trace) begin
			t = `FDD_TYPE_TRACE;
			s = {8'h00, f.trace, 1'b0};
		end
		return {multi, t, s};
	endfunction

	assign enc  = fdd_encode(fault_i);
	assign fault_ready_o = (state_ff == S_IDLE) || (state_ff == S_HANDLER);
	// Interrupt context is not looked at: faults there take this same path.
	assign take = fault_ready_o && (enc[23:16] != 8'h00);
	assign step = mreq_o.valid && mack_i;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			S_IDLE, S_HANDLER: begin
				if (take) begin
					nxt_state = state_i.incomplete ? S_WR_RES : S_WR_REC;
				end else if (state_ff == S_HANDLER && hdone_i) begin
					nxt_state = S_IDLE;
				end
			end
			S_WR_RES: if (step && ofs_ff == `FDD_RES_OFS1) nxt_state = S_WR_REC;
			S_WR_REC: if (step && ofs_ff == `FDD_REC_IP_OFS) nxt_state = S_RD_ENT0;
			S_RD_ENT0: if (step) nxt_state = S_RD_ENT1;
			S_RD_ENT1: begin
				if (step) begin
					if (ent0_ff[1:0] == `FDD_ENT_LOCAL) begin
						nxt_state = S_CALL;
					end else if (ent0_ff[1:0] == `FDD_ENT_SYSTEM) begin
						nxt_state = S_RD_SYS;
					end else begin
						nxt_state = S_IDLE;
					end
				end
			end
			S_RD_SYS: if (step) nxt_state = S_CALL;
			S_CALL: nxt_state = S_HANDLER;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Snapshot of program state and the encoded fault word at the moment of capture.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			snap_ff  <= '0;
			fword_ff <= 32'h00000000;
		end else if (take) begin
			snap_ff  <= state_i;
			fword_ff <= {8'h00, enc[23:0]};
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ofs_ff <= 8'h00;
		end else if (take) begin
			ofs_ff <= state_i.incomplete ? `FDD_RES_OFS0 : `FDD_REC_PC_OFS;
		end else if (step && state_ff == S_WR_RES && ofs_ff == `FDD_RES_OFS1) begin
			ofs_ff <= `FDD_REC_PC_OFS;
		end else if (step && (state_ff == S_WR_RES || state_ff == S_WR_REC)) begin
			ofs_ff <= ofs_ff + 8'h04;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rec_done_ff <= 1'b0;
		end else if (take) begin
			rec_done_ff <= 1'b0;
		end else if (step && state_ff == S_WR_REC && ofs_ff == `FDD_REC_IP_OFS) begin
			rec_done_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ent0_ff <= 32'h00000000;
		end else if (step && state_ff == S_RD_ENT0) begin
			ent0_ff <= mrdata_i;
		end
	end

	// Memory request: record words go to the current stack, then two table words.
	always_comb begin
		mreq_o = '0;
		unique case (state_ff)
			S_WR_RES, S_WR_REC: begin
				mreq_o.valid = 1'b1;
				mreq_o.we    = 1'b1;
				mreq_o.addr  = snap_ff.sp + {24'h000000, ofs_ff};
				unique case (ofs_ff)
					`FDD_RES_OFS0:   mreq_o.wdata = snap_ff.resume0;
					`FDD_RES_OFS1:   mreq_o.wdata = snap_ff.resume1;
					`FDD_REC_PC_OFS: mreq_o.wdata = snap_ff.proc_ctrl;
					`FDD_REC_AC_OFS: mreq_o.wdata = snap_ff.arith_ctrl;
					`FDD_REC_FW_OFS: mreq_o.wdata = fword_ff;
					default:         mreq_o.wdata = snap_ff.ip;
				endcase
			end
			S_RD_ENT0: begin
				mreq_o.valid = rec_done_ff;
				mreq_o.addr  = tbase_ff + {21'h000000, fword_ff[23:16], 3'b000};
			end
			S_RD_ENT1: begin
				mreq_o.valid = 1'b1;
				mreq_o.addr  = tbase_ff + {21'h000000, fword_ff[23:16], 3'b000}
					+ `FDD_ENT_WORD2;
			end
			S_RD_SYS: begin
				mreq_o.valid = 1'b1;
				mreq_o.addr  = sbase_ff + {ent0_ff[31:2], 2'b00};
			end
			default: mreq_o = '0;
		endcase
	end

	// Handler call: kind and target follow the entry type and the procedure word.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			call_info_ff <= '{kind: FDD_CALL_LOCAL, target: 32'h00000000,
				fault_word: 32'h00000000};
		end else if (step && state_ff == S_RD_ENT1 && ent0_ff[1:0] == `FDD_ENT_LOCAL) begin
			call_info_ff.kind       <= FDD_CALL_LOCAL;
			call_info_ff.target     <= {ent0_ff[31:2], 2'b00};
			call_info_ff.fault_word <= fword_ff;
		end else if (step && state_ff == S_RD_SYS) begin
			call_info_ff.kind       <= (mrdata_i[1:0] == `FDD_SYS_SUPER) ? FDD_CALL_SUPER
				: FDD_CALL_SYS_LOCAL;
			call_info_ff.target     <= {mrdata_i[31:2], 2'b00};
			call_info_ff.fault_word <= fword_ff;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			call_ff <= 1'b0;
		end else begin
			call_ff <= (nxt_state == S_CALL);
		end
	end

	assign call_o      = call_ff;
	assign call_info_o = call_info_ff;

	// Events. A fault taken inside a handler is still dispatched, but what the
	// program makes of that is undefined; software is only told it happened.
	assign ev[`FDD_IRQ_DISPATCH] = call_ff;
	assign ev[`FDD_IRQ_DROPPED]  = take && enc[24];
	assign ev[`FDD_IRQ_NESTED]   = take && (state_ff == S_HANDLER);
	assign ev[`FDD_IRQ_BADENT]   = step && state_ff == S_RD_ENT1
		&& ent0_ff[1:0] != `FDD_ENT_LOCAL && ent0_ff[1:0] != `FDD_ENT_SYSTEM;

	logic wr_acc;
	logic rd_setup;
	logic mapped;
	assign wr_acc   = apb_i.psel && apb_i.penable && apb_i.pwrite;
	assign rd_setup = apb_i.psel && !apb_i.penable && !apb_i.pwrite;
	assign mapped   = apb_i.paddr[7:6] == 2'b01 || apb_i.paddr[7:5] == 3'b000;

	// A set arriving together with its clear wins, so no event is lost.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_stat_ff <= 4'h0;
		end else if (wr_acc && apb_i.paddr == `FDD_REG_IRQ_CLR) begin
			irq_stat_ff <= (irq_stat_ff & ~apb_i.pwdata[3:0]) | ev;
		end else begin
			irq_stat_ff <= irq_stat_ff | ev;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tbase_ff  <= `FDD_TBASE_RST;
			sbase_ff  <= `FDD_SBASE_RST;
			irq_en_ff <= 4'h0;
		end else if (wr_acc) begin
			if (apb_i.paddr == `FDD_REG_TBASE) tbase_ff <= apb_i.pwdata;
			if (apb_i.paddr == `FDD_REG_SBASE) sbase_ff <= apb_i.pwdata;
			if (apb_i.paddr == `FDD_REG_IRQ_EN) irq_en_ff <= apb_i.pwdata[3:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_ff <= 32'h00000000;
		end else if (call_ff) begin
			count_ff <= count_ff + 32'h00000001;
		end
	end

	assign irq_o = |(irq_stat_ff & irq_en_ff);

	// Read data is prepared in the setup cycle, so the slave never inserts waits.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_ff <= 32'h00000000;
			win_ff    <= 1'b0;
		end else if (rd_setup) begin
			win_ff <= apb_i.paddr[7:6] == 2'b01;
			unique case (apb_i.paddr)
				`FDD_REG_TBASE:    prdata_ff <= tbase_ff;
				`FDD_REG_SBASE:    prdata_ff <= sbase_ff;
				`FDD_REG_STAT:     prdata_ff <= {27'h0000000, in_intr_i, rec_done_ff,
					(state_ff == S_HANDLER), fault_ready_o, (state_ff != S_IDLE)};
				`FDD_REG_FWORD:    prdata_ff <= fword_ff;
				`FDD_REG_IRQ_STAT: prdata_ff <= {28'h0000000, irq_stat_ff};
				`FDD_REG_IRQ_EN:   prdata_ff <= {28'h0000000, irq_en_ff};
				`FDD_REG_COUNT:    prdata_ff <= count_ff;
				default:           prdata_ff <= 32'h00000000;
			endcase
		end
	end

	fdd_rec_mem u_rec_mem (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.we_i    (step && mreq_o.we),
		.waddr_i (ofs_ff[5:2]),
		.wdata_i (mreq_o.wdata),
		.raddr_i (apb_i.paddr[5:2]),
		.rdata_o (mem_rdata)
	);

	assign pready_o  = 1'b1;
	assign pslverr_o = apb_i.psel && apb_i.penable && !mapped;
	assign prdata_o  = win_ff ? mem_rdata : prdata_ff;

	sequence seq_records_done;
		state_ff == S_WR_REC && step && ofs_ff == `FDD_REC_IP_OFS;
	endsequence

	sequence seq_call_after_entry;
		(state_ff == S_RD_ENT1 || state_ff == S_RD_SYS) && step ##1 call_o;
	endsequence

	chk_fetch_after_rec: assert property (@(posedge clk_i) disable iff (rst_i)
		(mreq_o.valid && !mreq_o.we) |-> rec_done_ff)
		else $error("Fault table read before record was complete");
	chk_fault_taken_now: assert property (@(posedge clk_i) disable iff (rst_i)
		(state_ff == S_IDLE && enc[23:16] != 8'h00) |=> state_ff != S_IDLE)
		else $error("Fault not serviced at once");
	chk_resume_pushed: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && state_i.incomplete) |=> state_ff == S_WR_RES && ofs_ff == `FDD_RES_OFS0)
		else $error("Resumption record not pushed");
	chk_fword_layout: assert property (@(posedge clk_i) disable iff (rst_i)
		(step && mreq_o.addr == snap_ff.sp + 32'h00000028)
			|-> mreq_o.wdata[23:0] == fword_ff[23:0] && fword_ff[23:16] != 8'h00)
		else $error("Fault word not at offset 40");
	chk_trace_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && fault_i == fdd_fault_t'{trace: 7'h7F, default: '0})
			|=> fword_ff[23:0] == 24'h0100FE)
		else $error("Trace flags not merged");
	chk_fp_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && fault_i.fp != 6'h00 && enc[23:16] == `FDD_TYPE_FP)
			|=> fword_ff[15:0] == {10'h000, $past(fault_i.fp)})
		else $error("Floating subtype flags wrong");
	chk_drop_one: assert property (@(posedge clk_i) disable iff (rst_i)
		(take && fault_i.mach && (fault_i.arith != 2'b00 || fault_i.oper != 3'h0))
			|=> fword_ff[23:0] == 24'h080001 && irq_stat_ff[`FDD_IRQ_DROPPED])
		else $error("Simultaneous faults not reduced to one");
	chk_call_kind: assert property (@(posedge clk_i) disable iff (rst_i)
		(call_o && call_info_o.kind == FDD_CALL_LOCAL) |-> ent0_ff[1:0] == `FDD_ENT_LOCAL)
		else $error("Local call from a non-local entry");
	chk_call_sequence: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_records_done |-> ##[2:200] (call_o || irq_stat_ff[`FDD_IRQ_BADENT] || take))
		else $error("Handler call did not follow the record");
	chk_call_source: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(call_o) |-> $past(state_ff) == S_RD_ENT1 || $past(state_ff) == S_RD_SYS)
		else $error("Handler call without a table entry");
endmodule

// File: sim/fdd_core_tb.sv
// Self-checking bench for fdd_core: word memory model, APB master, fault rows.
// Assumes the block package, its constants header and a 10 MHz clock.
`timescale 1ns/10ps
`include "fdd_consts.svh"
module fdd_core_tb
	import fdd_pkg::*;
;
	typedef struct packed {
		fdd_fault_t f;
		logic [31:0] fw;
		fdd_call_t   kind;
	} fdd_row_t;

	logic           clk_i;
	logic           rst_i = 1'b1;
	fdd_fault_t     fault_i = '0;
	fdd_state_t     state_i = '0;
	logic           in_intr_i = 1'b0;
	logic           hdone_i = 1'b0;
	logic           mack_i = 1'b0;
	logic [31:0]    mrdata_i = 32'h0;
	fdd_apb_req_t   apb_i = '0;
	logic           fault_ready_o;
	logic           call_o;
	fdd_call_info_t call_info_o;
	fdd_mreq_t      mreq_o;
	logic           pready_o;
	logic           pslverr_o;
	logic [31:0]    prdata_o;
	logic           irq_o;
	int             num_errors = 0;
	int             checks = 0;
	int             cyc = 0;
	int             wr_cnt = 0;
	logic [31:0]    mem [logic [31:0]];
	logic [31:0]    rd_q [$];
	logic           called;
	logic [31:0]    sp;
	logic [31:0]    r;
	logic           e;

	// Table entries: local for most types, system entries for types 3 and 4.
	fdd_row_t rows [18] = '{
		'{'{trace:7'h01, default:'0}, 32'h00010002, FDD_CALL_LOCAL},
		'{'{trace:7'h40, default:'0}, 32'h00010080, FDD_CALL_LOCAL},
		'{'{trace:7'h41, default:'0}, 32'h00010082, FDD_CALL_LOCAL},
		'{'{trace:7'h7F, default:'0}, 32'h000100FE, FDD_CALL_LOCAL},
		'{'{oper:3'h1, default:'0}, 32'h00020001, FDD_CALL_LOCAL},
		'{'{oper:3'h2, default:'0}, 32'h00020002, FDD_CALL_LOCAL},
		'{'{oper:3'h4, default:'0}, 32'h00020004, FDD_CALL_LOCAL},
		'{'{arith:2'h1, default:'0}, 32'h00030001, FDD_CALL_SUPER},
		'{'{arith:2'h2, default:'0}, 32'h00030002, FDD_CALL_SUPER},
		'{'{fp:6'h01, default:'0}, 32'h00040001, FDD_CALL_SYS_LOCAL},
		'{'{fp:6'h20, default:'0}, 32'h00040020, FDD_CALL_SYS_LOCAL},
		'{'{fp:6'h3F, default:'0}, 32'h0004003F, FDD_CALL_SYS_LOCAL},
		'{'{constr:2'h1, default:'0}, 32'h00050001, FDD_CALL_LOCAL},
		'{'{constr:2'h2, default:'0}, 32'h00050002, FDD_CALL_LOCAL},
		'{'{prot:1'b1, default:'0}, 32'h00070001, FDD_CALL_LOCAL},
		'{'{mach:1'b1, default:'0}, 32'h00080001, FDD_CALL_LOCAL},
		'{'{interagent_message:1'b1, default:'0}, 32'h00090003, FDD_CALL_LOCAL},
		'{'{type_mm:1'b1, default:'0}, 32'h000A0001, FDD_CALL_LOCAL}
	};

	fdd_core dut (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.fault_i       (fault_i),
		.state_i       (state_i),
		.in_intr_i     (in_intr_i),
		.fault_ready_o (fault_ready_o),
		.call_o        (call_o),
		.call_info_o   (call_info_o),
		.hdone_i       (hdone_i),
		.mreq_o        (mreq_o),
		.mack_i        (mack_i),
		.mrdata_i      (mrdata_i),
		.apb_i         (apb_i),
		.pready_o      (pready_o),
		.pslverr_o     (pslverr_o),
		.prdata_o      (prdata_o),
		.irq_o         (irq_o)
	);

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			conclude();
		end
	end

	// Memory acks every other cycle; idle read data toggles so stale values never match.
	always @(posedge clk_i) begin
		if (mreq_o.valid && !mack_i) begin
			mack_i <= 1'b1;
			if (mreq_o.we) begin
				mem[mreq_o.addr] = mreq_o.wdata;
				wr_cnt++;
			end else begin
				chk(32'(wr_cnt >= 4), 32'h1);
				rd_q.push_back(mreq_o.addr);
				mrdata_i <= mem.exists(mreq_o.addr) ? mem[mreq_o.addr] : 32'h0;
			end
		end else begin
			mack_i <= 1'b0;
			mrdata_i <= ~mrdata_i;
		end
	end

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk_i);
		apb_i <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d};
		@(posedge clk_i);
		apb_i.penable <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask

	task irqchk(input logic exp);
		@(negedge clk_i);
		chk(32'(irq_o), 32'(exp));
	endtask

	task fire(input fdd_fault_t f, input int i);
		wr_cnt = 0;
		rd_q.delete();
		sp = 32'h00008000 + (i << 8);
		@(posedge clk_i);
		fault_i <= f;
		in_intr_i <= i[0];
		state_i <= '{proc_ctrl:32'hA0000000 + i, arith_ctrl:32'hB0000000 + i,
			ip:32'hC0000000 + i, sp:sp, resume0:32'hD0000000 + i,
			resume1:32'hE0000000 + i, incomplete:i[0]};
		@(posedge clk_i);
		fault_i <= '0;
		called = 1'b0;
		for (int n = 0; n < 200 && !called; n++) begin
			@(posedge clk_i);
			called = (call_o === 1'b1);
		end
	endtask

	task hdone;
		@(posedge clk_i);
		hdone_i <= 1'b1;
		@(posedge clk_i);
		hdone_i <= 1'b0;
	endtask

	initial begin
		for (int t = 1; t <= 10; t++) begin
			mem[32'h00001000 + t * 8] = t << 12;
			mem[32'h00001004 + t * 8] = 32'h0;
		end
		mem[32'h00001018] = 32'h00000012;
		mem[32'h00001810] = 32'h00003002;
		mem[32'h00001020] = 32'h00000016;
		mem[32'h00001814] = 32'h00004000;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'(call_o), 32'h0);
		chk(32'(fault_ready_o), 32'h1);
		chk(32'(pready_o), 32'h1);
		rdchk(`FDD_REG_TBASE, `FDD_TBASE_RST);
		rdchk(`FDD_REG_SBASE, `FDD_SBASE_RST);
		rdchk(`FDD_REG_IRQ_STAT, 32'h0);
		rdchk(`FDD_REG_COUNT, 32'h0);
		wr(`FDD_REG_TBASE, 32'h00001000);
		wr(`FDD_REG_SBASE, 32'h00001800);
		rdchk(`FDD_REG_TBASE, 32'h00001000);
		apb(1'b0, 8'h30, 32'h0, r, e);
		chk(32'(e), 32'h1);
		chk(r, 32'h0);
		for (int i = 0; i < 18; i++) begin
			fire(rows[i].f, i);
			chk(32'(called), 32'h1);
			chk(call_info_o.fault_word, rows[i].fw);
			chk(32'(call_info_o.kind), 32'(rows[i].kind));
			chk(call_info_o.target, {12'h000, rows[i].fw[23:16], 12'h000});
			chk(mem[sp + `FDD_REC_FW_OFS], rows[i].fw);
			chk(mem[sp + `FDD_REC_PC_OFS], 32'hA0000000 + i);
			chk(mem[sp + `FDD_REC_IP_OFS], 32'hC0000000 + i);
			if (i[0])
				chk(mem[sp + `FDD_RES_OFS1], 32'hE0000000 + i);
			chk(rd_q[0], 32'h00001000 + (rows[i].fw[23:16] << 3));
			chk(rd_q[1], 32'h00001004 + (rows[i].fw[23:16] << 3));
			hdone();
		end
		rdchk(`FDD_REG_FWORD, 32'h000A0001);
		rdchk(`FDD_REG_WIN + `FDD_REC_FW_OFS, 32'h000A0001);
		rdchk(`FDD_REG_COUNT, 32'd18);
		wr(`FDD_REG_IRQ_CLR, 32'hF);
		rdchk(`FDD_REG_IRQ_STAT, 32'h0);
		rdchk(`FDD_REG_IRQ_CLR, 32'h0);
		// An entry type of 01 is not a legal handler path, so no call may follow.
		mem[32'h00001040] = 32'h00008001;
		fire('{mach:1'b1, default:'0}, 17);
		chk(32'(called), 32'h0);
		rdchk(`FDD_REG_IRQ_STAT, 32'h8);
		mem[32'h00001040] = 32'h00008000;
		wr(`FDD_REG_IRQ_CLR, 32'hF);
		wr(`FDD_REG_IRQ_EN, 32'h1);
		irqchk(1'b0);
		fire('{mach:1'b1, oper:3'h1, default:'0}, 18);
		chk(call_info_o.fault_word, 32'h00080001);
		// A fault inside the handler has no defined outcome; only its flag is looked at.
		fire('{trace:7'h01, default:'0}, 19);
		hdone();
		rdchk(`FDD_REG_IRQ_STAT, 32'h7);
		irqchk(1'b1);
		wr(`FDD_REG_IRQ_CLR, 32'h1);
		irqchk(1'b0);
		wr(`FDD_REG_IRQ_EN, 32'h2);
		irqchk(1'b1);
		wr(`FDD_REG_IRQ_CLR, 32'hF);
		irqchk(1'b0);
		// A reset in the middle of a record build must leave nothing half done.
		@(posedge clk_i);
		fault_i <= '{mach:1'b1, default:'0};
		@(posedge clk_i);
		fault_i <= '0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(32'(mreq_o.valid), 32'h0);
		chk(32'(call_o), 32'h0);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk(32'(fault_ready_o), 32'h1);
		rdchk(`FDD_REG_TBASE, `FDD_TBASE_RST);
		rdchk(`FDD_REG_COUNT, 32'h0);
		rdchk(`FDD_REG_IRQ_STAT, 32'h0);
		conclude();
	end
endmodule
